// ### nco_pkg.sv
package nco_pkg;

   localparam int ACC_W = 20;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // Register byte addresses
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_CLOCK_CFG = 8'h04;
   localparam logic [7:0] OFS_ACC_LOW   = 8'h08;
   localparam logic [7:0] OFS_ACC_HIGH  = 8'h0C;
   localparam logic [7:0] OFS_ACC_UPPER = 8'h10;
   localparam logic [7:0] OFS_INC_LOW   = 8'h14;
   localparam logic [7:0] OFS_INC_HIGH  = 8'h18;
   localparam logic [7:0] OFS_INC_UPPER = 8'h1C;
   localparam logic [7:0] OFS_IRQ       = 8'h20;

   // Control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_OUT_BIT    = 5;
   localparam int CTL_INVERT_BIT = 4;
   localparam int CTL_PULSE_BIT  = 0;

   // Clock configuration fields
   localparam int CFG_PWS_LSB = 5;
   localparam int CFG_CKS_LSB = 0;
   localparam int SEL_W       = 3;

   // Interrupt register fields
   localparam int IRQ_FLAG_BIT   = 0;
   localparam int IRQ_ENABLE_BIT = 1;
   localparam int IRQ_PERIPH_BIT = 2;
   localparam int IRQ_GLOBAL_BIT = 3;

   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 20'h0_0000;

   // Buffered increment load: ticks from the low byte write to the load
   localparam logic [1:0] LOAD_TICKS = 2'h2;
   localparam logic [1:0] LOAD_LAST  = 2'h1;

   typedef enum logic [2:0] {
      CKS_FAST_OSC   = 3'b000,
      CKS_SYSTEM     = 3'b001,
      CKS_LOGIC_CELL = 3'b010
   } clock_source_e;

endpackage

// ### numerically_controlled_osc.sv
`timescale 1ns/1ps
// Function
// RULE1: 20-bit accumulator, readable and writable bytewise
// RULE2: Each selected clock edge adds increment
// RULE3: Adder carry is the raw overflow
// RULE4: Three-bit field picks the input clock
// RULE5: 20-bit increment in low, high, upper bytes
// RULE6: Enabled: low write loads buffers, second edge
// RULE7: Software writes upper, high before low
// RULE8: Disabled: increment writes load buffers immediately
// RULE9: Control bit 7 enables the module
// RULE10: Fixed duty mode toggles output per overflow
// RULE11: Control bit 0 clear selects fixed duty
// RULE12: Pulse mode: active next edge, N periods
// RULE13: Control bit 0 set selects pulse mode
// RULE14: Pulse width field sets active periods
// RULE15: Pulse longer than interval keeps output active
// RULE16: Polarity bit 4 inverts final output
// RULE17: Polarity change with interrupts on flags
// RULE18: Read-only bit 5 shows final output
// RULE19: Overflow sets flag; request needs four enables
// RULE20: Software clears flag; hardware never does
// RULE21: Reset clears every register to zero
// RULE22: Runs in sleep; holds fast oscillator on
// RULE23: Clock-domain crossings are synchronised safely
module numerically_controlled_osc #(
   parameter int PWS_W = 3
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Clock sources from outside this domain
   input  wire logic        fast_osc_clk,
   input  wire logic        logic_cell_output,
   // Results
   output logic             nco_out,
   output logic             overflow_event,
   output logic             fast_osc_keep_on
);

   localparam int W = nco_pkg::ACC_W;
   localparam int PCNT_W = (1 << PWS_W) + 1;

   initial begin
      if (PWS_W < 1 || PWS_W > 4) begin
         $error("PWS_W must be 1 to 4");
      end
      // Byte lanes assume the accumulator spans exactly three bytes
      if (W <= 16 || W > 24) begin
         $error("Accumulator width must be 17 to 24");
      end
      // A zero countdown would never load the buffers
      if (nco_pkg::LOAD_TICKS == 2'h0) begin
         $error("Load delay must be at least one tick");
      end
   end

   // Pulse length in input clock periods: 1, 2, 4 ... per field value
   function automatic logic [PCNT_W-1:0] pulse_periods(input logic [PWS_W-1:0] sel);
      logic [PCNT_W-1:0] one;
      one = {{(PCNT_W-1){1'b0}}, 1'b1};
      pulse_periods = one << sel;
   endfunction

   function automatic logic [7:0] byte_of(input logic [W-1:0] v, input int idx);
      logic [23:0] wide;
      wide = {{(24-W){1'b0}}, v};
      byte_of = wide[idx*8 +: 8];
   endfunction

   // Registers
   logic [7:0]         control_reg;
   logic [7:0]         clock_cfg_reg;
   logic [W-1:0]       acc_reg;
   logic [W-1:0]       inc_reg;
   logic [W-1:0]       inc_buf_reg;
   logic [1:0]         load_wait_reg;
   logic               flag_reg;
   logic               irq_en_reg;
   logic               periph_en_reg;
   logic               global_en_reg;
   logic               raw_reg;
   logic               pulse_pend_reg;
   logic [PCNT_W-1:0]  pulse_cnt_reg;
   logic [1:0]         fast_sync_reg;
   logic [1:0]         cell_sync_reg;
   logic               fast_last_reg;
   logic               cell_last_reg;

   logic               enabled;
   logic               inverted;
   logic               pulse_mode;
   logic [PWS_W-1:0]   pws;
   logic [2:0]         cks;
   logic               tick;
   logic [W:0]         sum;
   logic               carry;
   logic               wr_en;
   logic               setup;
   logic               ints_on;
   logic               final_next;
   logic               invert_change;
   // Write strobes, one per register
   logic               wr_control;
   logic               wr_clock_cfg;
   logic               wr_acc_low;
   logic               wr_acc_high;
   logic               wr_acc_upper;
   logic               wr_inc_low;
   logic               wr_inc_high;
   logic               wr_inc_upper;
   logic               wr_irq;
   // Read path assembled ahead of the answer flop
   logic [7:0]         rd_byte;
   logic               rd_miss;

   assign enabled    = control_reg[nco_pkg::CTL_ENABLE_BIT];   // [RULE9]
   assign inverted   = control_reg[nco_pkg::CTL_INVERT_BIT];
   assign pulse_mode = control_reg[nco_pkg::CTL_PULSE_BIT];    // [RULE11] [RULE13]
   assign pws        = clock_cfg_reg[nco_pkg::CFG_PWS_LSB +: PWS_W];
   assign cks        = clock_cfg_reg[nco_pkg::CFG_CKS_LSB +: nco_pkg::SEL_W];
   assign setup      = psel && !penable;
   assign wr_en      = psel && penable && pwrite && pready;
   assign ints_on    = irq_en_reg && periph_en_reg && global_en_reg;

   // Decode once so every process agrees on which register is hit
   assign wr_control   = wr_en && paddr == nco_pkg::OFS_CONTROL;
   assign wr_clock_cfg = wr_en && paddr == nco_pkg::OFS_CLOCK_CFG;
   assign wr_acc_low   = wr_en && paddr == nco_pkg::OFS_ACC_LOW;
   assign wr_acc_high  = wr_en && paddr == nco_pkg::OFS_ACC_HIGH;
   assign wr_acc_upper = wr_en && paddr == nco_pkg::OFS_ACC_UPPER;
   assign wr_inc_low   = wr_en && paddr == nco_pkg::OFS_INC_LOW;
   assign wr_inc_high  = wr_en && paddr == nco_pkg::OFS_INC_HIGH;
   assign wr_inc_upper = wr_en && paddr == nco_pkg::OFS_INC_UPPER;
   assign wr_irq       = wr_en && paddr == nco_pkg::OFS_IRQ;

   // Outside clocks: two flops, then edge detect reads only the second
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fast_sync_reg <= 2'h0;
         cell_sync_reg <= 2'h0;
         fast_last_reg <= 1'b0;
         cell_last_reg <= 1'b0;
      end else begin
         fast_sync_reg <= {fast_sync_reg[0], fast_osc_clk};      // [RULE23]
         cell_sync_reg <= {cell_sync_reg[0], logic_cell_output}; // [RULE23]
         fast_last_reg <= fast_sync_reg[1];
         cell_last_reg <= cell_sync_reg[1];
      end
   end

   // Rising edge of the selected source; system clock ticks every cycle
   always_comb begin
      case (cks)                                                 // [RULE4]
         nco_pkg::CKS_FAST_OSC:   tick = fast_sync_reg[1] && !fast_last_reg;
         nco_pkg::CKS_SYSTEM:     tick = 1'b1;
         nco_pkg::CKS_LOGIC_CELL: tick = cell_sync_reg[1] && !cell_last_reg;
         default:                 tick = 1'b0;
      endcase
   end

   assign sum   = {1'b0, acc_reg} + {1'b0, inc_buf_reg};
   assign carry = enabled && tick && sum[W];                     // [RULE3]

   // Read mux; unused bits read as zero, but clock configuration bits 4 and 3 read back as written; status bit 5 shows the live output
   always_comb begin
      rd_byte = nco_pkg::BYTE_ZERO;
      rd_miss = 1'b0;
      if (paddr == nco_pkg::OFS_CONTROL) begin
         rd_byte                       = control_reg;
         rd_byte[nco_pkg::CTL_OUT_BIT] = nco_out;                // [RULE18]
      end else if (paddr == nco_pkg::OFS_CLOCK_CFG) begin
         rd_byte = clock_cfg_reg;
      end else if (paddr == nco_pkg::OFS_ACC_LOW) begin
         rd_byte = byte_of(acc_reg, 0);                          // [RULE1]
      end else if (paddr == nco_pkg::OFS_ACC_HIGH) begin
         rd_byte = byte_of(acc_reg, 1);
      end else if (paddr == nco_pkg::OFS_ACC_UPPER) begin
         rd_byte = byte_of(acc_reg, 2);
      end else if (paddr == nco_pkg::OFS_INC_LOW) begin
         rd_byte = byte_of(inc_reg, 0);                          // [RULE5]
      end else if (paddr == nco_pkg::OFS_INC_HIGH) begin
         rd_byte = byte_of(inc_reg, 1);
      end else if (paddr == nco_pkg::OFS_INC_UPPER) begin
         rd_byte = byte_of(inc_reg, 2);
      end else if (paddr == nco_pkg::OFS_IRQ) begin
         rd_byte[nco_pkg::IRQ_FLAG_BIT]   = flag_reg;
         rd_byte[nco_pkg::IRQ_ENABLE_BIT] = irq_en_reg;
         rd_byte[nco_pkg::IRQ_PERIPH_BIT] = periph_en_reg;
         rd_byte[nco_pkg::IRQ_GLOBAL_BIT] = global_en_reg;
      end else begin
         rd_miss = 1'b1;
      end
   end

   // APB handshake: one wait-free access phase, answer registered
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= nco_pkg::WORD_ZERO;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && rd_miss;
         if (setup) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Control and configuration; control bits 6, 5 and 3 to 1 never stored
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         control_reg   <= nco_pkg::BYTE_ZERO;                    // [RULE21]
         clock_cfg_reg <= nco_pkg::BYTE_ZERO;
      end else begin
         if (wr_control) begin
            // Status bit is not stored: it always shows the live output
            control_reg                          <= nco_pkg::BYTE_ZERO; // [RULE18]
            control_reg[nco_pkg::CTL_ENABLE_BIT] <= pwdata[nco_pkg::CTL_ENABLE_BIT];
            control_reg[nco_pkg::CTL_INVERT_BIT] <= pwdata[nco_pkg::CTL_INVERT_BIT];
            control_reg[nco_pkg::CTL_PULSE_BIT]  <= pwdata[nco_pkg::CTL_PULSE_BIT];
         end
         if (wr_clock_cfg) begin
            clock_cfg_reg <= pwdata[7:0];
         end
      end
   end

   // Software-visible increment bytes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         inc_reg <= nco_pkg::ACC_ZERO;
      end else if (wr_inc_low) begin
         inc_reg[7:0] <= pwdata[7:0];                            // [RULE5]
      end else if (wr_inc_high) begin
         inc_reg[15:8] <= pwdata[7:0];
      end else if (wr_inc_upper) begin
         inc_reg[W-1:16] <= pwdata[W-17:0];
      end
   end

   // Hidden buffers; enabled updates rely on high and upper being written first
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         inc_buf_reg   <= nco_pkg::ACC_ZERO;
         load_wait_reg <= 2'h0;
      end else if (!enabled) begin
         load_wait_reg <= 2'h0;
         if (wr_inc_low) begin
            inc_buf_reg[7:0] <= pwdata[7:0];                     // [RULE8]
         end else if (wr_inc_high) begin
            inc_buf_reg[15:8] <= pwdata[7:0];                    // [RULE8]
         end else if (wr_inc_upper) begin
            inc_buf_reg[W-1:16] <= pwdata[W-17:0];               // [RULE8]
         end
      end else if (wr_inc_low) begin
         // Counting selected ticks, not core cycles, keeps the load in step
         load_wait_reg <= nco_pkg::LOAD_TICKS;                   // [RULE6] [RULE7]
      end else if (tick && load_wait_reg != 2'h0) begin
         load_wait_reg <= load_wait_reg - 2'h1;
         if (load_wait_reg == nco_pkg::LOAD_LAST) begin
            inc_buf_reg <= inc_reg;                              // [RULE6]
         end
      end
   end

   // Accumulator: a software byte write wins over the addition
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_reg <= nco_pkg::ACC_ZERO;
      end else if (wr_acc_low) begin
         acc_reg[7:0] <= pwdata[7:0];                            // [RULE1]
      end else if (wr_acc_high) begin
         acc_reg[15:8] <= pwdata[7:0];
      end else if (wr_acc_upper) begin
         acc_reg[W-1:16] <= pwdata[W-17:0];
      end else if (enabled && tick) begin
         acc_reg <= sum[W-1:0];                                  // [RULE2]
      end
   end

   // Output shaping before polarity
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         raw_reg        <= 1'b0;
         pulse_pend_reg <= 1'b0;
         pulse_cnt_reg  <= '0;
      end else if (!enabled) begin
         raw_reg        <= 1'b0;
         pulse_pend_reg <= 1'b0;
         pulse_cnt_reg  <= '0;
      end else if (!pulse_mode) begin
         pulse_pend_reg <= 1'b0;
         pulse_cnt_reg  <= '0;
         if (carry) begin
            raw_reg <= !raw_reg;                                 // [RULE10]
         end
      end else if (tick) begin
         pulse_pend_reg <= carry;
         if (pulse_pend_reg) begin
            // Retrigger while active keeps the output high
            raw_reg       <= 1'b1;                               // [RULE12] [RULE15]
            pulse_cnt_reg <= pulse_periods(pws) - 1'b1;          // [RULE14]
         end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
         end else begin
            raw_reg <= 1'b0;                                     // [RULE12]
         end
      end
   end

   assign final_next    = raw_reg ^ inverted;                    // [RULE16]
   assign invert_change = wr_control &&
                          (pwdata[nco_pkg::CTL_INVERT_BIT] != inverted);

   // Interrupt enables
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_en_reg    <= 1'b0;
         periph_en_reg <= 1'b0;
         global_en_reg <= 1'b0;
      end else if (wr_irq) begin
         irq_en_reg    <= pwdata[nco_pkg::IRQ_ENABLE_BIT];
         periph_en_reg <= pwdata[nco_pkg::IRQ_PERIPH_BIT];
         global_en_reg <= pwdata[nco_pkg::IRQ_GLOBAL_BIT];
      end
   end

   // Flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag_reg <= 1'b0;
      end else if (carry || (invert_change && ints_on)) begin
         flag_reg <= 1'b1;                                       // [RULE19] [RULE17]
      end else if (wr_irq) begin
         // Writing one leaves the flag alone, so a lost clear is never invented
         flag_reg <= flag_reg && pwdata[nco_pkg::IRQ_FLAG_BIT];  // [RULE20]
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         nco_out          <= 1'b0;
         overflow_event   <= 1'b0;
         fast_osc_keep_on <= 1'b0;
      end else begin
         nco_out          <= final_next;                         // [RULE16]
         overflow_event   <= enabled && flag_reg && ints_on;     // [RULE19]
         // Source must not stop in sleep while we run from it
         fast_osc_keep_on <= enabled && cks == nco_pkg::CKS_FAST_OSC; // [RULE22]
      end
   end

endmodule

// ### nco_src_model.sv
`timescale 1ns/1ps
module nco_src_model (
   // Bench control
   input  wire logic lc_run,
   // Clock sources
   output logic      fast_osc_clk,
   output logic      logic_cell_output
);
   // Free-running oscillator, phase offset keeps its edges clear of the core edges
   initial begin
      fast_osc_clk = 1'b0;
      #1.3;
      forever #20 fast_osc_clk = ~fast_osc_clk;
   end
   // Logic cell line only moves while the bench asks for it
   initial begin
      logic_cell_output = 1'b0;
      #0.7;
      forever begin
         #30;
         logic_cell_output = lc_run ? ~logic_cell_output : 1'b0;
      end
   end
endmodule

// ### numerically_controlled_osc_chk.sv
`timescale 1ns/1ps
module nco_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rstn,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Results
   input wire logic        overflow_event,
   input wire logic        fast_osc_keep_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   property p_ready_once;
      pready |=> !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("answer held too long");
   property p_no_req;
      !psel |=> !pready;
   endproperty
   a_no_req: assert property (p_no_req) else $error("answer without request");
   property p_unmapped;
      psel && !penable && !pwrite && paddr > 8'h20 |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_mapped;
      psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_upper_zero;
      pready |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_reserved;
      pready && !pwrite && paddr == 8'h00 |-> !prdata[6] && prdata[3:1] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved control bits");
   property p_irq_off;
      psel && !penable && pwrite && paddr == 8'h20 && !pwdata[1] |=> ##[1:3] !overflow_event;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request with enable off");
   property p_keep_off;
      psel && !penable && pwrite && paddr == 8'h00 && !pwdata[7] |=> ##[1:3] !fast_osc_keep_on;
   endproperty
   a_keep_off: assert property (p_keep_off) else $error("oscillator held when off");
endmodule
bind numerically_controlled_osc nco_chk u_chk (.core_clk(core_clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .overflow_event(overflow_event),
   .fast_osc_keep_on(fast_osc_keep_on));

// ### numerically_controlled_osc_tb_top.sv
`timescale 1ns/1ps
module numerically_controlled_osc_tb_top;
   logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, lc_run, err;
   logic        fast_osc_clk, logic_cell_output, nco_out, overflow_event, fast_osc_keep_on;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          bad_count, checks;

   numerically_controlled_osc dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .fast_osc_clk(fast_osc_clk),
      .logic_cell_output(logic_cell_output), .nco_out(nco_out),
      .overflow_event(overflow_event), .fast_osc_keep_on(fast_osc_keep_on));
   nco_src_model src (.lc_run(lc_run), .fast_osc_clk(fast_osc_clk),
      .logic_cell_output(logic_cell_output));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic report_and_stop();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, {24'h00_0000, exp}, rd);
   endtask

   // Counts rising edges of the output over n cycles
   task automatic rises(input int n, input int exp, input string what);
      int r;
      logic p;
      r = 0;
      p = nco_out;
      repeat (n) begin
         @(posedge core_clk);
         if (nco_out === 1'b1 && p !== 1'b1) r++;
         p = nco_out;
      end
      chk(what, 32'(exp), 32'(r));
   endtask

   task automatic t_reset();
      for (int i = 0; i <= 8; i++) rdc("reset value", 8'(i * 4), 8'h00);
      apb(1'b0, 8'h24, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, err});
      chk("unmapped data", 32'h0000_0000, rd);
      // Zero increment: no overflow, so output sits inactive and shows the inversion
      wr(nco_pkg::OFS_CONTROL, 8'hFF);
      repeat (4) @(posedge core_clk);
      rdc("control", nco_pkg::OFS_CONTROL, 8'hB1);
      chk("inverted out", 32'h1, {31'h0, nco_out});
      chk("keep on", 32'h1, {31'h0, fast_osc_keep_on});
      wr(nco_pkg::OFS_CONTROL, 8'h00);
   endtask

   task automatic t_fdc();
      wr(nco_pkg::OFS_ACC_LOW, 8'h56);
      wr(nco_pkg::OFS_ACC_UPPER, 8'h0A);
      rdc("acc low", nco_pkg::OFS_ACC_LOW, 8'h56);
      rdc("acc upper", nco_pkg::OFS_ACC_UPPER, 8'h0A);
      wr(nco_pkg::OFS_INC_UPPER, 8'h08);
      rdc("inc upper", nco_pkg::OFS_INC_UPPER, 8'h08);
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h01);
      wr(nco_pkg::OFS_CONTROL, 8'h80);
      repeat (8) @(posedge core_clk);
      rises(40, 10, "fdc rises");
   endtask

   task automatic t_pulse();
      wr(nco_pkg::OFS_CONTROL, 8'h81);
      repeat (8) @(posedge core_clk);
      rises(40, 20, "pulse rises");
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h41);
      repeat (8) @(posedge core_clk);
      rises(40, 0, "long pulse");
      chk("long pulse level", 32'h1, {31'h0, nco_out});
   endtask

   task automatic t_buffer();
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h01);
      wr(nco_pkg::OFS_CONTROL, 8'h80);
      wr(nco_pkg::OFS_INC_UPPER, 8'h00);
      wr(nco_pkg::OFS_INC_HIGH, 8'h00);
      rises(40, 10, "before low write");
      wr(nco_pkg::OFS_INC_LOW, 8'h00);
      repeat (4) @(posedge core_clk);
      rises(40, 0, "after low write");
   endtask

   task automatic t_irq();
      wr(nco_pkg::OFS_INC_UPPER, 8'h08);
      wr(nco_pkg::OFS_INC_LOW, 8'h00);
      wr(nco_pkg::OFS_IRQ, 8'h0E);
      repeat (4) @(posedge core_clk);
      chk("request on", 32'h1, {31'h0, overflow_event});
      rdc("flag kept", nco_pkg::OFS_IRQ, 8'h0F);
      wr(nco_pkg::OFS_CONTROL, 8'h00);
      repeat (3) @(posedge core_clk);
      chk("request disabled", 32'h0, {31'h0, overflow_event});
      wr(nco_pkg::OFS_IRQ, 8'h0E);
      rdc("flag cleared", nco_pkg::OFS_IRQ, 8'h0E);
      wr(nco_pkg::OFS_CONTROL, 8'h10);
      repeat (4) @(posedge core_clk);
      rdc("polarity flag", nco_pkg::OFS_IRQ, 8'h0F);
      wr(nco_pkg::OFS_IRQ, 8'h00);
   endtask

   task automatic t_sources();
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h00);
      wr(nco_pkg::OFS_CONTROL, 8'h80);
      repeat (40) @(posedge core_clk);
      rises(320, 10, "fast osc rises");
      lc_run <= 1'b1;
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h02);
      repeat (60) @(posedge core_clk);
      rises(480, 10, "logic cell rises");
      chk("keep off", 32'h0, {31'h0, fast_osc_keep_on});
      wr(nco_pkg::OFS_CLOCK_CFG, 8'h03);
      repeat (8) @(posedge core_clk);
      rises(40, 0, "no source");
      lc_run <= 1'b0;
   endtask

   initial begin
      bad_count = 0;
      checks    = 0;
      rstn      = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0000_0000;
      lc_run    = 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_fdc();
      t_pulse();
      t_buffer();
      t_irq();
      t_sources();
      report_and_stop();
   end
endmodule
